// *** ssc_pkg.sv ***
// Purpose: constants for the standalone strap configuration loader
// Assumes: 8-bit registers at 7-bit register addresses
// Notes: field positions are shared by the top module and its assertions
package ssc_pkg;

	// ---------------------------------------------
	// register addresses
	// ---------------------------------------------
	localparam logic [6:0] SSC_ADDR_CTRL_A = 7'h00;
	localparam logic [6:0] SSC_ADDR_CTRL_B = 7'h01;
	localparam logic [6:0] SSC_ADDR_CTRL_C = 7'h02;
	localparam logic [6:0] SSC_ADDR_ROUTE = 7'h03;
	localparam logic [6:0] SSC_ADDR_MUX = 7'h04;
	localparam logic [6:0] SSC_ADDR_FORMAT = 7'h05;
	localparam logic [6:0] SSC_ADDR_ERRMASK = 7'h06;
	localparam logic [6:0] SSC_ADDR_LAST = 7'h7f;

	// ---------------------------------------------
	// field positions
	// ---------------------------------------------
	// receiver_control_a
	localparam int SSC_A_FORCE_CLK = 6;
	localparam int SSC_A_PD_RATE = 3;
	localparam int SSC_A_WORD_TRUNCATE = 2;
	// receiver_control_b
	localparam int SSC_B_SWCLK = 7;
	localparam int SSC_B_MUTE = 6;
	localparam int SSC_B_HOLD_LO = 2;
	localparam int SSC_B_RECOVERED_MASTER_CLOCK_RATIO = 1;
	localparam int SSC_B_CHAN = 0;
	// receiver_control_c
	localparam int SSC_C_DEEMPH_LO = 4;
	// input_mux_control
	localparam int SSC_M_RUN = 7;
	localparam int SSC_M_RXD = 6;
	localparam int SSC_M_RX_LO = 3;
	localparam int SSC_M_TX_LO = 0;
	// serial_output_format
	localparam int SSC_F_MASTER = 7;
	localparam int SSC_F_CLKFREQ = 6;
	localparam int SSC_F_RES_LO = 4;
	localparam int SSC_F_RJUST = 3;
	localparam int SSC_F_DELAY = 2;
	localparam int SSC_F_BITPOL = 1;
	localparam int SSC_F_WORDPOL = 0;
	// error_mask
	localparam int SSC_E_SUBCRC = 6;
	localparam int SSC_E_STATCRC = 5;
	localparam int SSC_E_LOCK = 4;
	localparam int SSC_E_CONF = 3;
	localparam int SSC_E_BIPH = 2;
	localparam int SSC_E_PAR = 1;
	localparam int SSC_E_VALID = 0;

	// ---------------------------------------------
	// values and timing
	// ---------------------------------------------
	localparam logic [7:0] SSC_REG_RESET = 8'h00;
	localparam logic [1:0] SSC_FMT_LJ = 2'h0;
	localparam logic [1:0] SSC_FMT_I2S = 2'h1;
	localparam logic [1:0] SSC_FMT_RJ = 2'h2;
	localparam logic [1:0] SSC_FMT_AES = 2'h3;
	localparam logic [1:0] SSC_RES_DIRECT = 2'h3;
	localparam int SSC_SYNC_DEPTH = 3;
	// cycles after reset release before the straps are latched
	localparam logic [2:0] SSC_SETTLE_CYC = 3'h4;

	typedef enum logic [1:0] {SSC_ST_SETTLE, SSC_ST_CAPTURE, SSC_ST_HOLD} ssc_state_t;

endpackage

// *** ssc_sync3.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to REF_CLK
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ssc_sync3 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// s1 is read only by s2, so metastability never reaches the filter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** ssc_edge_flag.sv ***
// Purpose: sticky flag set by a chosen edge of a filtered level
// Assumes: input already synchronised
// Notes: cleared only by reset
`timescale 1ns/100ps
`default_nettype none
module ssc_edge_flag #(
	parameter bit RISING = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic lvl,
	output logic flag
);
	logic prev_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			flag <= 1'b0;
		end else begin
			prev_r <= lvl;
			// arm masks the first cycles, when the filter still shows its reset value
			if (arm && (RISING ? (lvl && !prev_r) : (!lvl && prev_r))) begin
				flag <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** ssc_strap_config.sv ***
// Purpose: standalone strap loader building equivalent register values
// Assumes: straps held by board resistors; error inputs on REF_CLK
// Notes: straps frozen after capture until the next reset
// Function
// - serial out strap low selects standalone mode
// - sample straps after the settle wait that follows reset release
// - pll rate strap picks detector rate
// - receive block strap selects port master
// - format bits from flag and status straps
// - formats 00 and 01 field encoding
// - formats 10 and 11 field encoding
// - side info strap picks clock ratio
// - emphasis strap sets top deemphasis bit
// - system clock rising edge enables switchover
// - error strap high also holds on validity
// - error strap low ignores validity bit
// - standalone error mask values
// - remaining standalone fields fixed
// - addresses 07h to 7fh read zero
// - status and user pins on word edges, standalone master only
// - chip select falling edge selects spi
// - reset holds all state, low power
`timescale 1ns/100ps
`default_nettype none
module ssc_strap_config
	import ssc_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SERIAL_AUDIO_OUT_PIN,
	input wire logic RECEIVE_BLOCK_PIN,
	input wire logic AUDIO_FLAG_PIN,
	input wire logic STATUS_BIT_PIN,
	input wire logic SIDE_INFO_PIN,
	input wire logic PLL_RATE_PIN,
	input wire logic EMPHASIS_STRAP,
	input wire logic ERROR_FLAG_PIN,
	input wire logic [1:0] RX_MUX_SEL_PIN,
	input wire logic [1:0] TX_MUX_SEL_PIN,
	input wire logic SYSTEM_CLOCK_IN,
	input wire logic CHIP_ADDR_BIT0,
	input wire logic CHIP_ADDR_BIT1,
	input wire logic OUTPUT_WORD_CLOCK,
	input wire logic STATUS_BIT_IN,
	input wire logic USER_BIT_IN,
	input wire logic VALIDITY_IN,
	input wire logic PARITY_ERR,
	input wire logic BIPHASE_ERR,
	input wire logic CONF_ERR,
	input wire logic LOCK_ERR,
	input wire logic [6:0] REG_ADDR,
	output logic [7:0] REG_RDATA,
	output logic HW_MODE,
	output logic CFG_VALID,
	output logic SWITCHOVER_EN,
	output logic SPI_MODE,
	output logic [1:0] I2C_ADDR,
	output logic HOLD_SAMPLE,
	output logic STATUS_BIT_OUT,
	output logic USER_BIT_OUT,
	output logic LOW_POWER
);
	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	localparam int NSTRAP = 12;
	logic [NSTRAP-1:0] strap_raw;
	logic [NSTRAP-1:0] strap_f;
	logic [3:0] live_f;
	logic sysclk_f, cs_f, addr1_f, wclk_f;
	assign strap_raw = {TX_MUX_SEL_PIN, RX_MUX_SEL_PIN, ERROR_FLAG_PIN, EMPHASIS_STRAP,
		PLL_RATE_PIN, SIDE_INFO_PIN, STATUS_BIT_PIN, AUDIO_FLAG_PIN, RECEIVE_BLOCK_PIN,
		SERIAL_AUDIO_OUT_PIN};
	ssc_sync3 #(.W(NSTRAP)) u_sync_strap (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.d(strap_raw),
		.q(strap_f)
	);
	ssc_sync3 #(.W(4)) u_sync_live (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.d({SYSTEM_CLOCK_IN, CHIP_ADDR_BIT0, CHIP_ADDR_BIT1, OUTPUT_WORD_CLOCK}),
		.q(live_f)
	);
	assign sysclk_f = live_f[3];
	assign cs_f = live_f[2];
	assign addr1_f = live_f[1];
	assign wclk_f = live_f[0];
	// ---------------------------------------------
	// capture sequence
	// ---------------------------------------------
	ssc_state_t state_r;
	logic [2:0] settle_r;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= SSC_ST_SETTLE;
			settle_r <= 3'h0;
		end else begin
			case (state_r)
				SSC_ST_SETTLE: begin
					settle_r <= settle_r + 3'h1;
					if (settle_r == SSC_SETTLE_CYC - 3'h1) begin
						state_r <= SSC_ST_CAPTURE;
					end
				end
				SSC_ST_CAPTURE: state_r <= SSC_ST_HOLD;
				SSC_ST_HOLD: state_r <= SSC_ST_HOLD;
				default: state_r <= SSC_ST_SETTLE;
			endcase
		end
	end
	// the settle wait covers the synchroniser depth plus one filter cycle
	logic [NSTRAP-1:0] strap_r;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_r <= '0;
		end else if (state_r == SSC_ST_CAPTURE) begin
			strap_r <= strap_f;
		end
	end
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LOW_POWER <= 1'b1;
			CFG_VALID <= 1'b0;
		end else begin
			LOW_POWER <= 1'b0;
			CFG_VALID <= (state_r == SSC_ST_CAPTURE) || CFG_VALID;
		end
	end
	logic hw_mode_c, master_c, receiver_error_policy_c;
	logic [1:0] fmt_c;
	assign hw_mode_c = !strap_r[0];
	assign master_c = strap_r[1];
	assign fmt_c = {strap_r[2], strap_r[3]};
	assign receiver_error_policy_c = strap_r[7];
	assign HW_MODE = CFG_VALID && hw_mode_c;
	// ---------------------------------------------
	// pin edge events
	// ---------------------------------------------
	ssc_edge_flag #(.RISING(1'b1)) u_swclk (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.arm(CFG_VALID),
		.lvl(sysclk_f),
		.flag(SWITCHOVER_EN)
	);
	ssc_edge_flag #(.RISING(1'b0)) u_spi (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.arm(CFG_VALID),
		.lvl(cs_f),
		.flag(SPI_MODE)
	);
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			I2C_ADDR <= 2'h0;
		end else if (!SPI_MODE) begin
			I2C_ADDR <= {addr1_f, cs_f};
		end
	end
	// ---------------------------------------------
	// equivalent register values
	// ---------------------------------------------
	function automatic logic [7:0] fmt_bits(input logic master, input logic [1:0] sel);
		logic [7:0] f;
		f = SSC_REG_RESET;
		f[SSC_F_MASTER] = master;
		case (sel)
			SSC_FMT_LJ: begin
			end
			SSC_FMT_I2S: begin
				f[SSC_F_DELAY] = 1'b1;
				f[SSC_F_WORDPOL] = 1'b1;
			end
			SSC_FMT_RJ: f[SSC_F_RJUST] = 1'b1;
			SSC_FMT_AES: f[SSC_F_RES_LO+:2] = SSC_RES_DIRECT;
			default: begin
			end
		endcase
		return f;
	endfunction
	logic [7:0] ctrl_a_c, ctrl_b_c, ctrl_c_c, mux_c, format_c, errmask_c;
	always_comb begin
		ctrl_a_c = SSC_REG_RESET;
		ctrl_b_c = SSC_REG_RESET;
		ctrl_c_c = SSC_REG_RESET;
		mux_c = SSC_REG_RESET;
		errmask_c = SSC_REG_RESET;
		ctrl_a_c[SSC_A_PD_RATE] = strap_r[5];
		ctrl_b_c[SSC_B_SWCLK] = SWITCHOVER_EN;
		ctrl_b_c[SSC_B_RECOVERED_MASTER_CLOCK_RATIO] = strap_r[4];
		ctrl_c_c[SSC_C_DEEMPH_LO+2] = strap_r[6];
		mux_c[SSC_M_RUN] = 1'b1;
		mux_c[SSC_M_RX_LO+:2] = strap_r[9:8];
		mux_c[SSC_M_TX_LO+:2] = strap_r[11:10];
		errmask_c[SSC_E_LOCK] = 1'b1;
		errmask_c[SSC_E_CONF] = 1'b1;
		errmask_c[SSC_E_BIPH] = 1'b1;
		errmask_c[SSC_E_PAR] = 1'b1;
		errmask_c[SSC_E_VALID] = receiver_error_policy_c;
		format_c = fmt_bits(master_c, fmt_c);
	end
	// ---------------------------------------------
	// register read port
	// ---------------------------------------------
	// unmapped reads zero
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= SSC_REG_RESET;
		end else if (!CFG_VALID) begin
			REG_RDATA <= SSC_REG_RESET;
		end else begin
			case (REG_ADDR)
				SSC_ADDR_CTRL_A: REG_RDATA <= ctrl_a_c;
				SSC_ADDR_CTRL_B: REG_RDATA <= ctrl_b_c;
				SSC_ADDR_CTRL_C: REG_RDATA <= ctrl_c_c;
				SSC_ADDR_ROUTE: REG_RDATA <= SSC_REG_RESET;
				SSC_ADDR_MUX: REG_RDATA <= mux_c;
				SSC_ADDR_FORMAT: REG_RDATA <= format_c;
				SSC_ADDR_ERRMASK: REG_RDATA <= errmask_c;
				default: REG_RDATA <= SSC_REG_RESET;
			endcase
		end
	end
	// ---------------------------------------------
	// sample hold policy
	// ---------------------------------------------
	logic hard_err_c;
	assign hard_err_c = PARITY_ERR || BIPHASE_ERR || CONF_ERR || LOCK_ERR;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HOLD_SAMPLE <= 1'b0;
		end else begin
			HOLD_SAMPLE <= HW_MODE && (hard_err_c || (receiver_error_policy_c && VALIDITY_IN));
		end
	end
	// ---------------------------------------------
	// status and user pins
	// ---------------------------------------------
	logic wclk_prev_r;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wclk_prev_r <= 1'b0;
			STATUS_BIT_OUT <= 1'b0;
			USER_BIT_OUT <= 1'b0;
		end else begin
			wclk_prev_r <= wclk_f;
			if (HW_MODE && master_c && (wclk_f != wclk_prev_r)) begin
				STATUS_BIT_OUT <= STATUS_BIT_IN;
				USER_BIT_OUT <= USER_BIT_IN;
			end
		end
	end
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	property p_capture_time;
		$rose(CFG_VALID) |-> $past(state_r) == SSC_ST_CAPTURE;
	endproperty
	a_capture_time: assert property (p_capture_time) else $error("capture at wrong time");
	property p_frozen;
		CFG_VALID ##1 CFG_VALID |-> $stable(strap_r);
	endproperty
	a_frozen: assert property (p_frozen) else $error("straps moved after capture");
	// mode must follow the filtered pin as it stood on the capture edge
	property p_hw_mode;
		$rose(CFG_VALID) |-> HW_MODE == !$past(strap_f[0]);
	endproperty
	a_hw_mode: assert property (p_hw_mode) else $error("mode strap misread");
	property p_fmt_i2s;
		CFG_VALID && fmt_c == SSC_FMT_I2S && REG_ADDR == SSC_ADDR_FORMAT
			|=> REG_RDATA[6:0] == 7'h05;
	endproperty
	a_fmt_i2s: assert property (p_fmt_i2s) else $error("i2s format bits wrong");
	property p_fmt_aes;
		CFG_VALID && fmt_c == SSC_FMT_AES && REG_ADDR == SSC_ADDR_FORMAT
			|=> REG_RDATA[6:0] == 7'h30;
	endproperty
	a_fmt_aes: assert property (p_fmt_aes) else $error("direct format bits wrong");
	property p_errmask;
		CFG_VALID && REG_ADDR == SSC_ADDR_ERRMASK |=> REG_RDATA == {7'h0f, receiver_error_policy_c};
	endproperty
	a_errmask: assert property (p_errmask) else $error("error mask wrong");
	property p_unmapped;
		REG_ADDR > SSC_ADDR_ERRMASK |=> REG_RDATA == SSC_REG_RESET;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_nonvalid_error_policy;
		HW_MODE && !receiver_error_policy_c && !hard_err_c |=> !HOLD_SAMPLE;
	endproperty
	a_nonvalid_error_policy: assert property (p_nonvalid_error_policy) else $error("validity not ignored");
	property p_receiver_error_policy;
		HW_MODE && receiver_error_policy_c && VALIDITY_IN |=> HOLD_SAMPLE;
	endproperty
	a_receiver_error_policy: assert property (p_receiver_error_policy) else $error("validity hold missing");
	property p_spi_sticky;
		SPI_MODE |=> SPI_MODE;
	endproperty
	a_spi_sticky: assert property (p_spi_sticky) else $error("spi mode dropped");
	property p_cu_quiet;
		!(HW_MODE && master_c) |=> $stable(STATUS_BIT_OUT) && $stable(USER_BIT_OUT);
	endproperty
	a_cu_quiet: assert property (p_cu_quiet) else $error("status pins moved in slave");
	c_capture: cover property ($rose(CFG_VALID) && HW_MODE);
	c_spi: cover property ($rose(SPI_MODE));
	c_swclk: cover property ($rose(SWITCHOVER_EN));
	c_hold: cover property (HOLD_SAMPLE);
endmodule
`default_nettype wire

// *** ssc_strap_board.sv ***
// Purpose: board resistors on the strap pins of the loader
// Assumes: every strap except the detector-rate pin has a fitted resistor
// Notes: an unfitted detector-rate pin reads low through the on-chip pull
`timescale 1ns/100ps
`default_nettype none
module ssc_strap_board (
	input wire logic [11:0] pull_up,
	input wire logic rate_fitted,
	output logic [11:0] pins
);
	// ---------------------------------------------
	// strap levels
	// ---------------------------------------------
	// detector-rate strap level gated by rate_fitted
	assign pins = {pull_up[11:6], rate_fitted & pull_up[5], pull_up[4:0]};
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the strap configuration loader
// Assumes: straps come from the board model, all other inputs from here
// Notes: each request leaves a note; the monitor pairs it with the result
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct {int k; logic [7:0] e; int w;} ssc_note_t;
	ssc_note_t q[$];
	logic clk, rst_n, fit, sck, a0, a1, wck, ci, ui, vi, pe, be, ce, le;
	logic hw, cfg, swo, spi, hold, co, uo, lp;
	logic [11:0] pu, p, e;
	wire logic [11:0] pins;
	logic [6:0] addr;
	logic [7:0] rdata;
	logic [1:0] i2c, cu;
	logic [31:0] seed, r;
	int fails, tests_run, cyc;
	string nm[9] = '{"", "HW_MODE", "CFG_VALID", "SWITCHOVER_EN", "SPI_MODE",
		"HOLD_SAMPLE", "LOW_POWER", "I2C_ADDR", "STATUS_USER_OUT"};

	ssc_strap_board board (.pull_up(pu), .rate_fitted(fit), .pins(pins));
	ssc_strap_config dut (.REF_CLK(clk), .RST_N(rst_n), .SERIAL_AUDIO_OUT_PIN(pins[0]),
		.RECEIVE_BLOCK_PIN(pins[1]), .AUDIO_FLAG_PIN(pins[2]), .STATUS_BIT_PIN(pins[3]),
		.SIDE_INFO_PIN(pins[4]), .PLL_RATE_PIN(pins[5]), .EMPHASIS_STRAP(pins[6]),
		.ERROR_FLAG_PIN(pins[7]), .RX_MUX_SEL_PIN(pins[9:8]), .TX_MUX_SEL_PIN(pins[11:10]),
		.SYSTEM_CLOCK_IN(sck), .CHIP_ADDR_BIT0(a0), .CHIP_ADDR_BIT1(a1),
		.OUTPUT_WORD_CLOCK(wck), .STATUS_BIT_IN(ci), .USER_BIT_IN(ui), .VALIDITY_IN(vi),
		.PARITY_ERR(pe), .BIPHASE_ERR(be), .CONF_ERR(ce), .LOCK_ERR(le), .REG_ADDR(addr),
		.REG_RDATA(rdata), .HW_MODE(hw), .CFG_VALID(cfg), .SWITCHOVER_EN(swo),
		.SPI_MODE(spi), .I2C_ADDR(i2c), .HOLD_SAMPLE(hold), .STATUS_BIT_OUT(co),
		.USER_BIT_OUT(uo), .LOW_POWER(lp));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [1:0] seen(input int k);
		case (k)
			1: return {1'b0, hw};
			2: return {1'b0, cfg};
			3: return {1'b0, swo};
			4: return {1'b0, spi};
			5: return {1'b0, hold};
			6: return {1'b0, lp};
			7: return i2c;
			default: return {co, uo};
		endcase
	endfunction

	task automatic chk_byte(input int a, input logic [7:0] x);
		tests_run++;
		if (rdata !== x) begin
			fails++;
			$display("unexpected REG_RDATA at %h expected %h seen %h", a, x, rdata);
		end
	endtask

	task automatic chk_bit(input int k, input logic [1:0] x);
		tests_run++;
		if (seen(k) !== x) begin
			fails++;
			$display("unexpected %s expected %b seen %b", nm[k], x, seen(k));
		end
	endtask

	// reads answer one edge later, so their notes wait one extra negedge
	task automatic rd(input logic [6:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		q.push_back('{100 + int'(a), x, 1});
	endtask

	task automatic fl(input int k, input logic [1:0] x);
		@(posedge clk);
		q.push_back('{k, {6'h00, x}, 0});
	endtask

	task automatic errs(input logic [4:0] v, input logic x);
		@(posedge clk);
		{le, ce, be, pe, vi} <= v;
		q.push_back('{5, {7'h00, x}, 1});
	endtask

	task automatic regs(input logic [11:0] s, input logic sw);
		logic [7:0] f;
		case ({s[2], s[3]})
			2'b01: f = 8'h05;
			2'b10: f = 8'h08;
			2'b11: f = 8'h30;
			default: f = 8'h00;
		endcase
		rd(7'h00, {4'h0, s[5], 3'h0});
		rd(7'h01, {sw, 5'h00, s[4], 1'b0});
		rd(7'h02, {1'b0, s[6], 6'h00});
		rd(7'h03, 8'h00);
		rd(7'h04, {3'b100, s[9:8], 1'b0, s[11:10]});
		rd(7'h05, {s[1], 1'b0, f[5:0]});
		rd(7'h06, {3'h0, 4'hf, s[7]});
		rd(7'h07, 8'h00);
		rd(7'h7f, 8'h00);
	endtask

	task automatic boot(input logic [11:0] s, input logic f);
		@(posedge clk);
		{rst_n, sck, wck, a0, a1, fit} <= {4'b0001, r[13], f};
		pu <= s;
		cu = 2'b00;
		repeat (16) @(posedge clk);
		fl(6, 2'b01);
		fl(2, 2'b00);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		fl(2, 2'b01);
		fl(6, 2'b00);
		fl(1, {1'b0, ~s[0]});
	endtask

	task automatic test_done();
		$display("tests_run %0d fails %0d", tests_run, fails);
		// a note still queued means a result never came, which is a failure too
		if (fails == 0 && tests_run > 0 && q.size() == 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// clock, monitor, timeout
	// ---------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(negedge clk) begin
		while (q.size() > 0 && q[0].w == 0) begin
			if (q[0].k >= 100) begin
				chk_byte(q[0].k - 100, q[0].e);
			end else begin
				chk_bit(q[0].k, q[0].e[1:0]);
			end
			void'(q.pop_front());
		end
		foreach (q[i]) begin
			q[i].w--;
		end
	end

	// whole run is about 480 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			test_done();
		end
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		{rst_n, fit, sck, a0, a1, wck, ci, ui, vi, pe, be, ce, le} = '0;
		pu = '0;
		addr = '0;
		seed = 32'he1659a7a;
		r = '0;
		// four formats in standalone mode, then one software-mode run
		for (int i = 0; i < 5; i++) begin
			r = rnd();
			p = {r[11:8], i[0] ^ i[1], r[6:4], i[0], i[1], i[1], i == 4};
			e = p;
			e[5] = p[5] & r[12];
			boot(p, r[12]);
			regs(e, 1'b0);
			fl(7, {a1, 1'b1});
			fl(3, 2'b00);
			fl(4, 2'b00);
			@(posedge clk);
			{sck, a0} <= 2'b10;
			pu <= ~p;
			repeat (10) @(posedge clk);
			fl(3, 2'b01);
			fl(4, 2'b01);
			fl(1, {1'b0, ~p[0]});
			regs(e, 1'b1);
			for (int j = 0; j < 5; j++) begin
				errs(5'h01 << j, ~p[0] & ((j != 0) | p[7]));
			end
			errs(5'h00, 1'b0);
			for (int j = 0; j < 2; j++) begin
				r = rnd();
				@(posedge clk);
				{ci, ui, wck} <= {r[1:0], ~wck};
				repeat (8) @(posedge clk);
				cu = (~p[0] & p[1]) ? r[1:0] : cu;
				fl(8, cu);
			end
		end
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule
`default_nettype wire
